// *** logic/wdw_pkg.sv ***
// wdw_pkg: constants for the windowed watchdog enable and clear logic
// assumes a single system clock at 20 MHz and one watchdog tick input
package wdw_pkg;

    // =====================================================================
    // counter geometry
    localparam int          WDW_CNT_W        = 16;
    localparam logic [15:0] WDW_PERIOD_RST   = 16'h0400;

    // =====================================================================
    // configuration word one field positions
    localparam int          WDW_CW1_W        = 16;
    localparam int          WDW_WINDOW_DISABLE_CFG_BIT   = 6;

    // =====================================================================
    // reset control register field positions
    localparam int          WDW_RCTL_W       = 16;
    localparam int          WDW_SWEN_BIT     = 5;

    // =====================================================================
    // watchdog reset request pulse length in clocks
    localparam logic [3:0]  WDW_RST_PULSE    = 4'h1;

    typedef enum logic [1:0] {
        WDW_ST_OFF  = 2'b00,
        WDW_ST_RUN  = 2'b01,
        WDW_ST_FIRE = 2'b10
    } wdw_state_type;

endpackage : wdw_pkg

// *** logic/wdw_sync.sv ***
// wdw_sync: two-flop synchroniser for one level
// assumes the input is asynchronous to i_clk_sys
`timescale 1ns/1ps
module wdw_sync (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    // data
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : wdw_sync

// *** logic/wdw_core.sv ***
// wdw_core: watchdog enable selection, windowed clear and timeout
// assumes clear and enable writes come from core logic on i_clk_sys; the
// fuse, period strap and tick come from outside and are synchronised here
`timescale 1ns/1ps
module wdw_core
    import wdw_pkg::*;
(
    // clock and reset
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rst_n,
    // configuration fuses (static pins)
    input  wire logic [wdw_pkg::WDW_CW1_W-1:0] i_config_word_one,
    input  wire logic                        i_fuse_watchdog_enable,
    input  wire logic [wdw_pkg::WDW_CNT_W-1:0] i_period,
    // watchdog clock tick (asynchronous level, counted on rising edge)
    input  wire logic                        i_wdt_tick,
    // core side
    input  wire logic                        i_clear_watchdog_instr,
    input  wire logic                        i_rctl_wr,
    input  wire logic [wdw_pkg::WDW_RCTL_W-1:0] i_rctl_wdata,
    // status and reset request
    output logic                             o_soft_watchdog_enable,
    output logic                             o_window_mode,
    output logic                             o_running,
    output logic [wdw_pkg::WDW_CNT_W-1:0]    o_count,
    output logic                             o_wdt_reset_req,
    output logic                             o_timeout_flag,
    output logic                             o_window_violation
);
    import wdw_pkg::*;

    // =====================================================================
    // input synchronisers
    logic fuse_s;
    logic window_disable_cfg_s;
    logic tick_s;
    logic tick_prev_q;
    logic [WDW_CNT_W-1:0] period_s;

    wdw_sync u_sync_fuse (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_fuse_watchdog_enable),
        .o_sync    (fuse_s)
    );
    // reset value 0 of window_disable_cfg_s briefly means window mode; harmless as the
    // counter is held in reset for the same two cycles
    wdw_sync u_sync_window_disable_cfg (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_config_word_one[WDW_WINDOW_DISABLE_CFG_BIT]),
        .o_sync    (window_disable_cfg_s)
    );
    wdw_sync u_sync_tick (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_wdt_tick),
        .o_sync    (tick_s)
    );

    // the period is a static strap, so each bit may cross alone; a period
    // changed while the watchdog runs could be seen half old, half new
    for (genvar gi = 0; gi < WDW_CNT_W; gi++) begin : g_period_sync
        wdw_sync u_sync_period (
            .i_clk_sys (i_clk_sys),
            .i_rst_n   (i_rst_n),
            .i_async   (i_period[gi]),
            .o_sync    (period_s[gi])
        );
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_prev_q <= 1'b0;
        end else begin
            tick_prev_q <= tick_s;
        end
    end

    logic tick_edge;
    assign tick_edge = tick_s & ~tick_prev_q;

    // =====================================================================
    // enable selection
    logic swen_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            swen_q <= 1'b0;
        end else if (i_rctl_wr) begin
            swen_q <= i_rctl_wdata[WDW_SWEN_BIT];
        end
    end

    logic enabled;
    logic window_mode;
    assign enabled     = fuse_s | swen_q;
    assign window_mode = ~window_disable_cfg_s;

    // =====================================================================
    // window decode: open once count reaches three quarters of period
    logic [WDW_CNT_W-1:0] cnt_q;
    logic [WDW_CNT_W-1:0] win_start;
    logic                 win_open;
    logic                 at_period;
    logic                 early_clear;
    logic                 good_clear;

    assign win_start   = period_s - (period_s >> 2);
    assign win_open    = cnt_q >= win_start;
    // the tick that would make the count reach the period is the timeout
    assign at_period   = tick_edge && (cnt_q >= period_s - 16'h0001);
    assign early_clear = enabled && i_clear_watchdog_instr && window_mode && !win_open;
    assign good_clear  = enabled && i_clear_watchdog_instr && !early_clear;

    // =====================================================================
    // state and counter
    wdw_state_type        st_q;
    logic [3:0]           pulse_q;
    // state decodes kept on flops so the reset request leaves glitch free
    logic                 run_q;
    logic                 req_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q    <= WDW_ST_OFF;
            cnt_q   <= 16'h0000;
            pulse_q <= 4'h0;
            run_q   <= 1'b0;
            req_q   <= 1'b0;
        end else begin
            case (st_q)
                WDW_ST_OFF: begin
                    cnt_q <= 16'h0000;
                    if (enabled) begin
                        st_q  <= WDW_ST_RUN;
                        run_q <= 1'b1;
                    end
                end
                WDW_ST_RUN: begin
                    if (!enabled) begin
                        st_q  <= WDW_ST_OFF;
                        cnt_q <= 16'h0000;
                        run_q <= 1'b0;
                    end else if (early_clear || (at_period && !good_clear)) begin
                        st_q    <= WDW_ST_FIRE;
                        cnt_q   <= 16'h0000;
                        pulse_q <= WDW_RST_PULSE;
                        run_q   <= 1'b0;
                        req_q   <= 1'b1;
                    end else if (good_clear) begin
                        // a late clear on the timeout tick still counts as serviced
                        cnt_q <= 16'h0000;
                    end else if (tick_edge) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                WDW_ST_FIRE: begin
                    if (pulse_q <= 4'h1) begin
                        pulse_q <= 4'h0;
                        st_q    <= enabled ? WDW_ST_RUN : WDW_ST_OFF;
                        run_q   <= enabled;
                        req_q   <= 1'b0;
                    end else begin
                        pulse_q <= pulse_q - 4'h1;
                    end
                end
                default: begin
                    st_q  <= WDW_ST_OFF;
                    run_q <= 1'b0;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // =====================================================================
    // sticky cause flags, cleared by device reset only
    logic tmo_q;
    logic viol_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tmo_q  <= 1'b0;
            viol_q <= 1'b0;
        end else if (st_q == WDW_ST_RUN && enabled) begin
            if (early_clear) begin
                viol_q <= 1'b1;
            end else if (at_period && !good_clear) begin
                tmo_q <= 1'b1;
            end
        end
    end

    // =====================================================================
    // outputs
    logic winm_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            winm_q <= 1'b0;
        end else begin
            winm_q <= window_mode;
        end
    end

    assign o_soft_watchdog_enable = swen_q;
    assign o_window_mode          = winm_q;
    assign o_running              = run_q;
    assign o_count                = cnt_q;
    assign o_wdt_reset_req        = req_q;
    assign o_timeout_flag         = tmo_q;
    assign o_window_violation     = viol_q;

endmodule : wdw_core

// *** test/wdw_core_chk.sv ***
// wdw_core_chk: port assertions for wdw_core
// assumes it is bound onto wdw_core, one clock domain
`timescale 1ns/1ps
module wdw_core_chk
    import wdw_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic        i_fuse_watchdog_enable,
    input wire logic [15:0] i_period,
    input wire logic        i_clear_watchdog_instr,
    input wire logic        i_rctl_wr,
    input wire logic [15:0] i_rctl_wdata,
    input wire logic        o_soft_watchdog_enable,
    input wire logic        o_window_mode,
    input wire logic        o_running,
    input wire logic [15:0] o_count,
    input wire logic        o_wdt_reset_req,
    input wire logic        o_timeout_flag,
    input wire logic        o_window_violation
);
    // =====================================================
    // clear, enable and timeout relations
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic        clr_taken;
    logic        wr_bit;
    logic [15:0] win_start;
    // clears in the reset pulse cycle are ignored, so leave them out
    assign clr_taken = o_running && !o_wdt_reset_req && i_clear_watchdog_instr;
    assign wr_bit    = i_rctl_wdata[WDW_SWEN_BIT];
    assign win_start = i_period - (i_period >> 2);
    sequence s_fire; o_wdt_reset_req && o_count == 16'h0000; endsequence
    sequence s_restart; !o_wdt_reset_req && o_count == 16'h0000; endsequence
    property p_good; clr_taken && o_window_mode && o_count >= win_start |=> s_restart; endproperty
    a_good: assert property (p_good) else $error("late clear not taken");
    property p_early; clr_taken && o_window_mode && o_count < win_start |=> s_fire ##0 o_window_violation; endproperty
    a_early: assert property (p_early) else $error("early clear no reset");
    property p_norm; clr_taken && !o_window_mode |=> s_restart; endproperty
    a_norm: assert property (p_norm) else $error("normal clear not taken");
    property p_swen; i_rctl_wr |=> o_soft_watchdog_enable == $past(wr_bit); endproperty
    a_swen: assert property (p_swen) else $error("soft enable write lost");
    property p_fuse; i_fuse_watchdog_enable [*6] |-> o_running || o_wdt_reset_req; endproperty
    a_fuse: assert property (p_fuse) else $error("fuse on but stopped");
    property p_idle; (!i_fuse_watchdog_enable && !o_soft_watchdog_enable) [*5] |-> !o_running; endproperty
    a_idle: assert property (p_idle) else $error("running while disabled");
    property p_pulse; o_wdt_reset_req |=> !o_wdt_reset_req; endproperty
    a_pulse: assert property (p_pulse) else $error("reset request too long");
    property p_tout; $rose(o_timeout_flag) |-> s_fire; endproperty
    a_tout: assert property (p_tout) else $error("timeout without reset");
endmodule : wdw_core_chk

// *** test/wdw_cpu_model.sv ***
// wdw_cpu_model: core side issuing clear instructions and enable writes
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module wdw_cpu_model (
    input  wire logic   i_clk_sys,
    output logic        o_clr,
    output logic        o_wr,
    output logic [15:0] o_wdata
);
    initial begin
        o_clr   = 1'b0;
        o_wr    = 1'b0;
        o_wdata = 16'h0000;
    end
    task automatic clear_instr;
        @(posedge i_clk_sys);
        #1 o_clr = 1'b1;
        @(posedge i_clk_sys);
        #1 o_clr = 1'b0;
    endtask : clear_instr
    // other bits opposite to the enable bit, and stale data inverted
    task automatic set_en(input logic en);
        @(posedge i_clk_sys);
        #1 o_wr = 1'b1;
        o_wdata = en ? 16'h0020 : 16'hFFDF;
        @(posedge i_clk_sys);
        #1 o_wr = 1'b0;
        o_wdata = ~o_wdata;
    endtask : set_en
endmodule : wdw_cpu_model

// *** test/wdw_core_bench.sv ***
// wdw_core_bench: directed run of wdw_core with a core model
// assumes a period of eight ticks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module wdw_core_bench;
    logic        i_clk_sys = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_fuse_watchdog_enable = 1'b0;
    logic        i_wdt_tick = 1'b0;
    logic [15:0] i_config_word_one = 16'hFFFF;
    logic [15:0] i_period = 16'h0008;
    logic        i_clear_watchdog_instr, i_rctl_wr, o_soft_watchdog_enable, o_window_mode, o_running;
    logic        o_wdt_reset_req, o_timeout_flag, o_window_violation;
    logic [15:0] i_rctl_wdata, o_count;
    int          fail_count = 0;
    int          n_checks = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    wdw_core DUT (.i_clk_sys, .i_rst_n, .i_config_word_one, .i_fuse_watchdog_enable, .i_period, .i_wdt_tick,
        .i_clear_watchdog_instr, .i_rctl_wr, .i_rctl_wdata, .o_soft_watchdog_enable, .o_window_mode,
        .o_running, .o_count, .o_wdt_reset_req, .o_timeout_flag, .o_window_violation);
    wdw_cpu_model cpu (.i_clk_sys, .o_clr(i_clear_watchdog_instr), .o_wr(i_rctl_wr), .o_wdata(i_rctl_wdata));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : cyc
    // ticks are slow against the clock: synchroniser needs two edges
    task automatic ticks(input int n);
        repeat (n) begin
            i_wdt_tick = 1'b1;
            cyc(2);
            i_wdt_tick = 1'b0;
            cyc(2);
        end
        cyc(2);
    endtask : ticks
    task automatic do_reset;
        i_rst_n = 1'b0;
        cyc(3);
        i_rst_n = 1'b1;
    endtask : do_reset
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic t_soft;
        `CHK("swen", 1'b0, o_soft_watchdog_enable)
        cpu.set_en(1'b1);
        cyc(1);
        `CHK("run", 1'b1, o_running)
        ticks(3);
        `CHK("count", 16'h0003, o_count)
        cpu.clear_instr();
        `CHK("count", 16'h0000, o_count)
        `CHK("viol", 1'b0, o_window_violation)
        ticks(7);
        `CHK("tout", 1'b0, o_timeout_flag)
        `CHK("count", 16'h0007, o_count)
        ticks(1);
        `CHK("tout", 1'b1, o_timeout_flag)
        `CHK("count", 16'h0000, o_count)
        cpu.set_en(1'b0);
        cyc(1);
        `CHK("run", 1'b0, o_running)
    endtask : t_soft
    task automatic t_window;
        i_config_word_one = 16'hFFBF;
        do_reset;
        cyc(4);
        `CHK("wmode", 1'b1, o_window_mode)
        cpu.set_en(1'b1);
        ticks(6);
        cpu.clear_instr();
        `CHK("count", 16'h0000, o_count)
        `CHK("viol", 1'b0, o_window_violation)
        ticks(5);
        cpu.clear_instr();
        `CHK("req", 1'b1, o_wdt_reset_req)
        `CHK("viol", 1'b1, o_window_violation)
    endtask : t_window
    task automatic t_fuse;
        i_fuse_watchdog_enable = 1'b1;
        cpu.set_en(1'b0);
        cyc(4);
        `CHK("run", 1'b1, o_running)
        cpu.set_en(1'b1);
        do_reset;
        cyc(4);
        `CHK("swen", 1'b0, o_soft_watchdog_enable)
        `CHK("run", 1'b1, o_running)
    endtask : t_fuse
    initial begin
        do_reset;
        t_soft;
        t_window;
        t_fuse;
        stop_test;
    end
    initial begin
        cyc(3000);
        fail_count++;
        stop_test;
    end
endmodule : wdw_core_bench
bind wdw_core wdw_core_chk u_chk (.i_clk_sys, .i_rst_n, .i_fuse_watchdog_enable, .i_period,
    .i_clear_watchdog_instr, .i_rctl_wr, .i_rctl_wdata, .o_soft_watchdog_enable, .o_window_mode,
    .o_running, .o_count, .o_wdt_reset_req, .o_timeout_flag, .o_window_violation);
